/* File: core/otp_sel_pkg.sv */
// Summary of operation
// - busy low while accepted internal work runs
// - only listed action commands and the refresh commands pull busy low
// - refresh ignores all but three read commands
// - store holds 8K bytes, 0 to 0x1fff
// - blank bit reads one, programming only clears
// - two equal 4K banks, check code at base
// - bank zero used when its code is 0xa5
// - else bank one if valid, otherwise abandon refresh
// - bank bytes 0x01-0x13 preload command defaults
// - sixteen boundaries from offset 0x1a in order
// - range tables packed back to back from 0x2a
// - first boundary not below temperature picks range
// - above every boundary selects final range table
// - waveform ends on groups done, zero repeat, zero frames
// - two zero-volt frames follow waveform end
// - vcom level code 0xff floats vcom
// - stored-table mode copies chosen range before the waveform
`default_nettype none
package otp_sel_pkg;
    localparam int          CLK_NS      = 50;
    localparam int          FRAME_NS    = 20000;
    localparam int          FRAME_CYC   = (FRAME_NS + CLK_NS - 1) / CLK_NS;
    localparam int          WORK_NS     = 10000;
    localparam int          WORK_CYC    = (WORK_NS + CLK_NS - 1) / CLK_NS;
    localparam int          OTP_BYTES   = 8192;
    localparam logic [7:0]  CHK_CODE    = 8'ha5;
    localparam logic [11:0] OFS_CHK     = 12'h000;
    localparam logic [11:0] OFS_DFLT    = 12'h001;
    localparam logic [8:0]  DFLT_LAST   = 9'h012;
    localparam logic [11:0] OFS_TB      = 12'h01a;
    localparam logic [8:0]  TB_LAST     = 9'h00f;
    localparam logic [11:0] OFS_TR      = 12'h02a;
    localparam logic [11:0] TR_LEN      = 12'h0e9;
    localparam logic [8:0]  TR_LAST     = 9'h0e8;
    localparam logic [4:0]  RNG_FINAL   = 5'h10;
    localparam logic [3:0]  GRP_TWO     = 4'h6;
    localparam logic [3:0]  GRP_THREE   = 4'h8;
    localparam logic [7:0]  STG_OFS     = 8'h09;
    localparam logic [7:0]  STG_LEN     = 8'h07;
    localparam logic [7:0]  LVL_FLOAT   = 8'hff;
    localparam logic [1:0]  TAIL_FRAMES = 2'h2;
    localparam logic [3:0]  RA_CTRL     = 4'h0;
    localparam logic [3:0]  RA_TEMP     = 4'h1;
    localparam logic [3:0]  RA_STATUS   = 4'h2;
    localparam logic [3:0]  RA_OTP_ADDR = 4'h3;
    localparam logic [3:0]  RA_OTP_DATA = 4'h4;
    localparam logic [3:0]  RA_LUT_IDX  = 4'h5;
    localparam logic [3:0]  RA_LUT_DATA = 4'h6;
    localparam logic [1:0]  CTRL_RST    = 2'h0;
    localparam logic [7:0]  TEMP_RST    = 8'h00;
    localparam logic [7:0]  CMD_POF     = 8'h02;
    localparam logic [7:0]  CMD_PON     = 8'h04;
    localparam logic [7:0]  CMD_POWER_MEASURE_CMD    = 8'h05;
    localparam logic [7:0]  CMD_DEEP_SLEEP_CMD    = 8'h07;
    localparam logic [7:0]  CMD_DSP     = 8'h11;
    localparam logic [7:0]  CMD_DRF     = 8'h12;
    localparam logic [7:0]  CMD_AUTO    = 8'h17;
    localparam logic [7:0]  CMD_TSC     = 8'h40;
    localparam logic [7:0]  CMD_LPD     = 8'h51;
    localparam logic [7:0]  CMD_REV     = 8'h70;
    localparam logic [7:0]  CMD_FLG     = 8'h71;
    localparam logic [7:0]  CMD_AMV     = 8'h80;
    localparam logic [7:0]  CMD_VV      = 8'h81;
    localparam logic [7:0]  CMD_APG     = 8'ha1;
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_WORK = 8'h02,
        ST_CHK0 = 8'h04,
        ST_CHK1 = 8'h08,
        ST_DFLT = 8'h10,
        ST_TB   = 8'h20,
        ST_COPY = 8'h40,
        ST_WAVE = 8'h80
    } ref_state_t;
endpackage
`default_nettype wire

/* File: core/otp_store.sv */
`default_nettype none
module otp_store (
    input  wire logic        sys_clk,
    input  wire logic [12:0] rd_addr,
    output logic      [7:0]  rd_data_ff,
    input  wire logic        pg_en,
    input  wire logic [12:0] pg_addr,
    input  wire logic [7:0]  pg_data
);
    logic [7:0] mem [0:otp_sel_pkg::OTP_BYTES-1];
    logic [7:0] old_ff;
    logic [7:0] new_ff;
    logic [12:0] pa_ff;

    // blank array; fuses are not cleared by reset
    initial
    begin
        for (int i = 0; i < otp_sel_pkg::OTP_BYTES; i++)
            mem[i] = 8'hff;
    end

    always_ff @(posedge sys_clk)
    begin
        if (pg_en)
            mem[pg_addr] <= mem[pg_addr] & pg_data;
        old_ff     <= mem[pg_addr];
        new_ff     <= mem[pg_addr] & pg_data;
        pa_ff      <= pg_addr;
        rd_data_ff <= mem[rd_addr];
    end

    default clocking @(posedge sys_clk); endclocking

    a_prog_clears: assert property (pg_en |=> mem[pa_ff] == new_ff && (new_ff & ~old_ff) == 8'h00)
        else $error("programming set a bit");
endmodule
`default_nettype wire

/* File: core/wave_end.sv */
`default_nettype none
module wave_end (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       start,
    input  wire logic       frame_tick,
    input  wire logic       two_colour_mode,
    input  wire logic [7:0] stg_level,
    input  wire logic [7:0] stg_repeat,
    input  wire logic       stg_frames_zero,
    output logic      [3:0] grp_ff,
    output logic            active_ff,
    output logic            zero_out_ff,
    output logic            vcom_float_ff,
    output logic            done_ff
);
    logic [1:0] tail_ff;
    wire  [3:0] grp_max  = two_colour_mode ? otp_sel_pkg::GRP_TWO : otp_sel_pkg::GRP_THREE;
    wire        end_cond = (grp_ff == grp_max) || (stg_repeat == 8'h00) || stg_frames_zero;
    wire        end_now  = active_ff && frame_tick && end_cond;
    wire        tail_end = zero_out_ff && frame_tick && (tail_ff == 2'h1);

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            grp_ff        <= 4'h0;
            active_ff     <= 1'b0;
            zero_out_ff   <= 1'b0;
            tail_ff       <= 2'h0;
            vcom_float_ff <= 1'b0;
            done_ff       <= 1'b0;
        end
        else
        begin
            done_ff       <= tail_end;
            vcom_float_ff <= active_ff && !end_now && (stg_level == otp_sel_pkg::LVL_FLOAT);
            if (start)
            begin
                grp_ff    <= 4'h0;
                active_ff <= 1'b1;
            end
            else if (end_now)
            begin
                active_ff   <= 1'b0;
                zero_out_ff <= 1'b1;
                tail_ff     <= otp_sel_pkg::TAIL_FRAMES;
            end
            else if (active_ff && frame_tick)
                grp_ff <= grp_ff + 4'h1;
            if (zero_out_ff && frame_tick)
            begin
                tail_ff <= tail_ff - 2'h1;
                if (tail_end)
                    zero_out_ff <= 1'b0;
            end
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_end_to_tail: assert property (end_now |=> zero_out_ff && !active_ff && tail_ff == 2'h2)
        else $error("waveform end did not start zero frames");
    a_float_level: assert property (active_ff && !end_now && stg_level == 8'hff |=> vcom_float_ff)
        else $error("vcom not floated on level ff");
endmodule
`default_nettype wire

/* File: core/otp_bank_temp_range_select.sv */
// Implementation choices: the strobed register port and the address map.
`default_nettype none
module otp_bank_temp_range_select (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata_ff,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_code,
    output logic             cmd_taken_ff,
    output logic             cmd_ignored_ff,
    output logic             busy_n_ff,
    output logic             refresh_abort_ff,
    output logic             wave_active,
    output logic             zero_frames,
    output logic             vcom_float
);
    otp_sel_pkg::ref_state_t st_ff, nxt_st;
    logic [8:0]  idx_ff, nxt_idx;
    logic        ph_ff;
    logic [7:0]  cnt_ff, nxt_cnt;
    logic        bank_ff, nxt_bank;
    logic [4:0]  rng_ff, nxt_rng;
    logic [1:0]  ctrl_ff;
    logic [7:0]  temp_ff;
    logic [12:0] sw_addr_ff;
    logic [8:0]  lut_idx_ff;
    logic [8:0]  fdiv_ff;
    logic        frame_tick_ff;
    logic        abort_set;
    logic [7:0]  lut_ram [0:otp_sel_pkg::TR_LAST];
    logic [7:0]  dflt_ram [0:otp_sel_pkg::DFLT_LAST];
    logic [7:0]  otp_q;
    logic [3:0]  grp;
    logic        wave_done;
    logic [10:0] zf_cyc_ff;

    // one read port, shared between the sequencer and software
    wire is_read  = (cmd_code == otp_sel_pkg::CMD_REV) || (cmd_code == otp_sel_pkg::CMD_FLG)
                 || (cmd_code == otp_sel_pkg::CMD_VV);
    wire is_drf   = (cmd_code == otp_sel_pkg::CMD_DSP) || (cmd_code == otp_sel_pkg::CMD_DRF);
    wire is_flag  = (cmd_code == otp_sel_pkg::CMD_POF) || (cmd_code == otp_sel_pkg::CMD_PON)
                 || (cmd_code == otp_sel_pkg::CMD_POWER_MEASURE_CMD) || (cmd_code == otp_sel_pkg::CMD_DEEP_SLEEP_CMD)
                 || (cmd_code == otp_sel_pkg::CMD_AUTO) || (cmd_code == otp_sel_pkg::CMD_TSC)
                 || (cmd_code == otp_sel_pkg::CMD_LPD) || (cmd_code == otp_sel_pkg::CMD_AMV)
                 || (cmd_code == otp_sel_pkg::CMD_APG);
    wire idle_ish  = (st_ff == otp_sel_pkg::ST_IDLE) || (st_ff == otp_sel_pkg::ST_WORK);
    wire refreshing = !idle_ish;
    wire accept    = cmd_valid && (idle_ish || is_read);
    wire reg_src   = ctrl_ff[0];
    wire two_col   = ctrl_ff[1];
    wire temp_le   = $signed(temp_ff) <= $signed(otp_q);

    wire [11:0] tr_base = otp_sel_pkg::OFS_TR + 12'(rng_ff) * otp_sel_pkg::TR_LEN;
    wire [11:0] ofs_dflt = otp_sel_pkg::OFS_DFLT + 12'(idx_ff);
    wire [11:0] ofs_tb   = otp_sel_pkg::OFS_TB + 12'(idx_ff);
    wire [11:0] ofs_tr   = tr_base + 12'(idx_ff);
    wire [11:0] seq_ofs  = (st_ff == otp_sel_pkg::ST_DFLT) ? ofs_dflt
                         : (st_ff == otp_sel_pkg::ST_TB) ? ofs_tb
                         : (st_ff == otp_sel_pkg::ST_COPY) ? ofs_tr : otp_sel_pkg::OFS_CHK;
    wire        seq_bank = (st_ff == otp_sel_pkg::ST_CHK1) ? 1'b1
                         : (st_ff == otp_sel_pkg::ST_CHK0) ? 1'b0 : bank_ff;
    wire [12:0] otp_rd_addr = idle_ish ? sw_addr_ff : {seq_bank, seq_ofs};

    wire wr_ctrl  = reg_wr && (reg_addr == otp_sel_pkg::RA_CTRL);
    wire wr_temp  = reg_wr && (reg_addr == otp_sel_pkg::RA_TEMP);
    wire wr_stat  = reg_wr && (reg_addr == otp_sel_pkg::RA_STATUS);
    wire wr_oaddr = reg_wr && (reg_addr == otp_sel_pkg::RA_OTP_ADDR);
    wire wr_odata = reg_wr && (reg_addr == otp_sel_pkg::RA_OTP_DATA);
    wire wr_lidx  = reg_wr && (reg_addr == otp_sel_pkg::RA_LUT_IDX);
    wire wr_ldata = reg_wr && (reg_addr == otp_sel_pkg::RA_LUT_DATA) && reg_src
                 && !lut_idx_ff[8] && (lut_idx_ff <= otp_sel_pkg::TR_LAST);
    wire copy_wr  = (st_ff == otp_sel_pkg::ST_COPY) && ph_ff;

    wire [7:0] lut_rd = lut_idx_ff[8] ? ((lut_idx_ff[7:0] <= 8'(otp_sel_pkg::DFLT_LAST))
                                         ? dflt_ram[lut_idx_ff[4:0]] : 8'h00)
                      : ((lut_idx_ff <= otp_sel_pkg::TR_LAST) ? lut_ram[lut_idx_ff[7:0]] : 8'h00);
    wire [15:0] status = {3'h0, rng_ff, 3'h0, zero_frames, wave_active, refresh_abort_ff,
                          bank_ff, !busy_n_ff};
    wire [15:0] rd_mux = (reg_addr == otp_sel_pkg::RA_CTRL) ? {14'h0000, ctrl_ff}
                       : (reg_addr == otp_sel_pkg::RA_TEMP) ? {8'h00, temp_ff}
                       : (reg_addr == otp_sel_pkg::RA_STATUS) ? status
                       : (reg_addr == otp_sel_pkg::RA_OTP_ADDR) ? {3'h0, sw_addr_ff}
                       : (reg_addr == otp_sel_pkg::RA_OTP_DATA) ? {8'h00, otp_q}
                       : (reg_addr == otp_sel_pkg::RA_LUT_IDX) ? {7'h00, lut_idx_ff}
                       : (reg_addr == otp_sel_pkg::RA_LUT_DATA) ? {8'h00, lut_rd} : 16'h0000;

    // current waveform stage lives in the first table of the copied range
    wire [7:0] stg_base = otp_sel_pkg::STG_OFS + 8'(grp) * otp_sel_pkg::STG_LEN;
    wire [7:0] stg_lvl  = lut_ram[stg_base];
    wire       stg_fz   = (lut_ram[stg_base + 8'h01] == 8'h00) && (lut_ram[stg_base + 8'h02] == 8'h00)
                       && (lut_ram[stg_base + 8'h03] == 8'h00) && (lut_ram[stg_base + 8'h04] == 8'h00);
    wire [7:0] stg_rpt  = lut_ram[stg_base + 8'h05];
    wire       wave_go  = (nxt_st == otp_sel_pkg::ST_WAVE) && (st_ff != otp_sel_pkg::ST_WAVE);

    always_comb
    begin
        nxt_st    = st_ff;
        nxt_idx   = idx_ff;
        nxt_cnt   = cnt_ff;
        nxt_bank  = bank_ff;
        nxt_rng   = rng_ff;
        abort_set = 1'b0;
        case (st_ff)
            otp_sel_pkg::ST_IDLE, otp_sel_pkg::ST_WORK:
            begin
                if (st_ff == otp_sel_pkg::ST_WORK)
                begin
                    nxt_cnt = cnt_ff - 8'h01;
                    if (cnt_ff == 8'h01)
                        nxt_st = otp_sel_pkg::ST_IDLE;
                end
                if (accept && is_drf)
                begin
                    nxt_st  = otp_sel_pkg::ST_CHK0;
                    nxt_idx = 9'h000;
                end
                else if (accept && is_flag)
                begin
                    nxt_st  = otp_sel_pkg::ST_WORK;
                    nxt_cnt = 8'(otp_sel_pkg::WORK_CYC);
                end
            end
            otp_sel_pkg::ST_CHK0:
            begin
                if (ph_ff && otp_q == otp_sel_pkg::CHK_CODE)
                begin
                    nxt_bank = 1'b0;
                    nxt_st   = otp_sel_pkg::ST_DFLT;
                end
                else if (ph_ff)
                    nxt_st = otp_sel_pkg::ST_CHK1;
            end
            otp_sel_pkg::ST_CHK1:
            begin
                if (ph_ff && otp_q == otp_sel_pkg::CHK_CODE)
                begin
                    nxt_bank = 1'b1;
                    nxt_st   = otp_sel_pkg::ST_DFLT;
                end
                else if (ph_ff)
                begin
                    nxt_st    = otp_sel_pkg::ST_IDLE;
                    abort_set = 1'b1;
                end
            end
            otp_sel_pkg::ST_DFLT:
            begin
                if (ph_ff)
                begin
                    nxt_idx = idx_ff + 9'h001;
                    if (idx_ff == otp_sel_pkg::DFLT_LAST)
                    begin
                        nxt_st  = otp_sel_pkg::ST_TB;
                        nxt_idx = 9'h000;
                    end
                end
            end
            otp_sel_pkg::ST_TB:
            begin
                if (ph_ff)
                begin
                    nxt_idx = idx_ff + 9'h001;
                    if (temp_le || idx_ff == otp_sel_pkg::TB_LAST)
                    begin
                        nxt_rng = temp_le ? idx_ff[4:0] : otp_sel_pkg::RNG_FINAL;
                        nxt_st  = reg_src ? otp_sel_pkg::ST_WAVE : otp_sel_pkg::ST_COPY;
                        nxt_idx = 9'h000;
                    end
                end
            end
            otp_sel_pkg::ST_COPY:
            begin
                if (ph_ff)
                begin
                    nxt_idx = idx_ff + 9'h001;
                    if (idx_ff == otp_sel_pkg::TR_LAST)
                        nxt_st = otp_sel_pkg::ST_WAVE;
                end
            end
            otp_sel_pkg::ST_WAVE:
            begin
                if (wave_done)
                    nxt_st = otp_sel_pkg::ST_IDLE;
            end
            default:
                nxt_st = otp_sel_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            st_ff     <= otp_sel_pkg::ST_IDLE;
            idx_ff    <= 9'h000;
            ph_ff     <= 1'b0;
            cnt_ff    <= 8'h00;
            bank_ff   <= 1'b0;
            rng_ff    <= 5'h00;
            busy_n_ff <= 1'b1;
        end
        else
        begin
            st_ff     <= nxt_st;
            idx_ff    <= nxt_idx;
            ph_ff     <= (nxt_st == st_ff) && idle_ish ? 1'b0 : ((nxt_st == st_ff) ? !ph_ff : 1'b0);
            cnt_ff    <= nxt_cnt;
            bank_ff   <= nxt_bank;
            rng_ff    <= nxt_rng;
            busy_n_ff <= (nxt_st == otp_sel_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            cmd_taken_ff     <= 1'b0;
            cmd_ignored_ff   <= 1'b0;
            ctrl_ff          <= otp_sel_pkg::CTRL_RST;
            temp_ff          <= otp_sel_pkg::TEMP_RST;
            sw_addr_ff       <= 13'h0000;
            lut_idx_ff       <= 9'h000;
            refresh_abort_ff <= 1'b0;
            reg_rdata_ff     <= 16'h0000;
            fdiv_ff          <= 9'h000;
            frame_tick_ff    <= 1'b0;
        end
        else
        begin
            cmd_taken_ff   <= accept;
            cmd_ignored_ff <= cmd_valid && !accept;
            reg_rdata_ff   <= reg_rd ? rd_mux : 16'h0000;
            // a new abort beats a software clear in the same cycle
            refresh_abort_ff <= abort_set || (refresh_abort_ff && !(wr_stat && reg_wdata[2]));
            frame_tick_ff  <= (fdiv_ff == 9'(otp_sel_pkg::FRAME_CYC - 1));
            fdiv_ff        <= (fdiv_ff == 9'(otp_sel_pkg::FRAME_CYC - 1)) ? 9'h000 : fdiv_ff + 9'h001;
            if (wr_ctrl)
                ctrl_ff <= reg_wdata[1:0];
            if (wr_temp)
                temp_ff <= reg_wdata[7:0];
            if (wr_oaddr)
                sw_addr_ff <= reg_wdata[12:0];
            else if (wr_odata)
                sw_addr_ff <= sw_addr_ff + 13'h0001;
            if (wr_lidx)
                lut_idx_ff <= reg_wdata[8:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (copy_wr)
            lut_ram[idx_ff[7:0]] <= otp_q;
        else if (wr_ldata)
            lut_ram[lut_idx_ff[7:0]] <= reg_wdata[7:0];
        if ((st_ff == otp_sel_pkg::ST_DFLT) && ph_ff)
            dflt_ram[idx_ff[4:0]] <= otp_q;
    end

    otp_store u_store (
        .sys_clk    (sys_clk),
        .rd_addr    (otp_rd_addr),
        .rd_data_ff (otp_q),
        .pg_en      (wr_odata),
        .pg_addr    (sw_addr_ff),
        .pg_data    (reg_wdata[7:0])
    );

    wave_end u_wave (
        .sys_clk         (sys_clk),
        .reset_n         (reset_n),
        .start           (wave_go),
        .frame_tick      (frame_tick_ff),
        .two_colour_mode (two_col),
        .stg_level       (stg_lvl),
        .stg_repeat      (stg_rpt),
        .stg_frames_zero (stg_fz),
        .grp_ff          (grp),
        .active_ff       (wave_active),
        .zero_out_ff     (zero_frames),
        .vcom_float_ff   (vcom_float),
        .done_ff         (wave_done)
    );

    // cycle count of the trailing frames, only for the bound below
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || !zero_frames)
            zf_cyc_ff <= 11'h000;
        else
            zf_cyc_ff <= zf_cyc_ff + 11'h001;
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_busy_falls: assert property (idle_ish && cmd_valid && is_flag && !is_drf |=> !busy_n_ff [*8])
        else $error("busy did not fall for action command");
    a_busy_rises: assert property (st_ff == otp_sel_pkg::ST_WORK && cnt_ff == 8'h01 && !cmd_valid
                                   |=> busy_n_ff)
        else $error("busy did not return high");
    a_no_flag_cmd: assert property (st_ff == otp_sel_pkg::ST_IDLE && cmd_valid && !is_flag && !is_drf
                                    |=> busy_n_ff)
        else $error("busy moved on plain command");
    a_refresh_ignore: assert property (refreshing && cmd_valid && !is_read
                                       |=> cmd_ignored_ff && !cmd_taken_ff)
        else $error("command taken during refresh");
    a_read_accepted: assert property (refreshing && cmd_valid && is_read |=> cmd_taken_ff)
        else $error("read command refused during refresh");
    a_bank_abort: assert property (st_ff == otp_sel_pkg::ST_CHK1 && ph_ff && otp_q != 8'ha5
                                   |=> st_ff == otp_sel_pkg::ST_IDLE && refresh_abort_ff)
        else $error("refresh not abandoned without valid bank");
    a_range_pick: assert property (st_ff == otp_sel_pkg::ST_TB && ph_ff && temp_le
                                   |=> rng_ff == $past(idx_ff[4:0]))
        else $error("wrong range selected");
    a_range_final: assert property (st_ff == otp_sel_pkg::ST_TB && ph_ff && !temp_le && idx_ff == 9'h00f
                                    |=> rng_ff == 5'h10)
        else $error("final range not selected");
    a_busy_lookup: assert property (refreshing |-> !busy_n_ff)
        else $error("busy high during lookup");
    a_tail_bound: assert property (zero_frames |-> zf_cyc_ff < 11'(3 * otp_sel_pkg::FRAME_CYC))
        else $error("zero frames did not finish");
    a_wave_ends: assert property ($fell(zero_frames) |=> busy_n_ff)
        else $error("busy not released after zero frames");
    a_abort_wins: assert property (abort_set |=> refresh_abort_ff)
        else $error("abort flag not set");
    a_copy_bank: assert property (st_ff == otp_sel_pkg::ST_COPY |-> otp_rd_addr[12] == bank_ff)
        else $error("copy read from wrong bank");

    c_bank_one: cover property (st_ff == otp_sel_pkg::ST_CHK1 ##1 st_ff == otp_sel_pkg::ST_DFLT);
    c_abort: cover property ($rose(refresh_abort_ff));
    c_final: cover property (st_ff == otp_sel_pkg::ST_COPY && rng_ff == 5'h10);
    c_float: cover property (vcom_float);
    c_range_hit: cover property (st_ff == otp_sel_pkg::ST_TB && ph_ff && temp_le);
endmodule
`default_nettype wire

/* File: verif/host_model.sv */
`default_nettype none
module host_model (
    input  wire logic       sys_clk,
    output logic            cmd_valid,
    output logic      [7:0] cmd_code
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code  = 8'h00;
    end
    // one-cycle pulse; stale code inverted so nothing leans on it
    task automatic send(input logic [7:0] c);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_code  <= c;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        cmd_code  <= ~c;
        #1;
    endtask
endmodule
`default_nettype wire

/* File: verif/otp_bank_temp_range_select_bench.sv */
`default_nettype none
module otp_bank_temp_range_select_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk, reset_n, reg_wr, reg_rd, cmd_valid, cmd_taken_ff, cmd_ignored_ff;
    logic        busy_n_ff, refresh_abort_ff, wave_active, zero_frames, vcom_float;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata_ff;
    logic [7:0]  cmd_code;
    int          failures, n_tests, cnt;
    otp_bank_temp_range_select DUT (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata_ff, .cmd_valid, .cmd_code, .cmd_taken_ff, .cmd_ignored_ff, .busy_n_ff,
        .refresh_abort_ff, .wave_active, .zero_frames, .vcom_float);
    host_model host (.sys_clk, .cmd_valid, .cmd_code);
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata_ff & m, exp);
    endtask
    // counts low cycles of busy, bounded so a stuck flag ends the run
    task automatic wait_idle(input int lim);
        cnt = 0;
        while (busy_n_ff !== 1'b1 && cnt < lim)
        begin
            @(posedge sys_clk);
            #1 cnt++;
        end
        if (cnt >= lim)
        begin
            chk(1'b0, 1'b1);
            report_and_stop();
        end
    endtask
    // waits for wave_active (zf=0) or zero_frames (zf=1), bounded
    task automatic wait_out(input logic zf, input int lim);
        cnt = 0;
        while ((zf ? zero_frames : wave_active) !== 1'b1 && cnt < lim)
        begin
            @(posedge sys_clk);
            #1 cnt++;
        end
        if (cnt >= lim)
        begin
            chk(16'h0000, 16'h0001);
            report_and_stop();
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic tk);
        host.send(c);
        chk({cmd_taken_ff, cmd_ignored_ff}, {tk, ~tk});
    endtask
    task automatic t_flags;
        cmd(8'h10, 1'b1);
        chk(busy_n_ff, 1'b1);
        cmd(otp_sel_pkg::CMD_POF, 1'b1);
        wait_idle(1000);
        chk(cnt[15:0], 16'(otp_sel_pkg::WORK_CYC));
        $display("flags done");
    endtask
    task automatic t_otp;
        wr(otp_sel_pkg::RA_OTP_ADDR, 16'h0005);
        rd(otp_sel_pkg::RA_OTP_DATA, 16'h00ff, 16'h00ff);
        wr(otp_sel_pkg::RA_OTP_DATA, 16'h000f);
        wr(otp_sel_pkg::RA_OTP_ADDR, 16'h0005);
        wr(otp_sel_pkg::RA_OTP_DATA, 16'h00f0);
        wr(otp_sel_pkg::RA_OTP_ADDR, 16'h0005);
        rd(otp_sel_pkg::RA_OTP_DATA, 16'h00ff, 16'h0000);
        wr(otp_sel_pkg::RA_OTP_ADDR, 16'h1fe0);
        wr(otp_sel_pkg::RA_OTP_DATA, 16'h00ff);
        wr(otp_sel_pkg::RA_OTP_ADDR, 16'h1fe0);
        rd(otp_sel_pkg::RA_OTP_DATA, 16'h00ff, 16'h00ff);
        $display("otp done");
    endtask
    task automatic t_refresh;
        cmd(otp_sel_pkg::CMD_DRF, 1'b1);
        wait_idle(300);
        rd(otp_sel_pkg::RA_STATUS, 16'h0004, 16'h0004);
        wr(otp_sel_pkg::RA_OTP_ADDR, 16'h1000);
        wr(otp_sel_pkg::RA_OTP_DATA, 16'h00a5);
        wr(otp_sel_pkg::RA_OTP_DATA, 16'h003c);
        wr(otp_sel_pkg::RA_OTP_ADDR, 16'h1eba);
        wr(otp_sel_pkg::RA_OTP_DATA, 16'h005a);
        wr(otp_sel_pkg::RA_STATUS, 16'h0004);
        cmd(otp_sel_pkg::CMD_DRF, 1'b1);
        cmd(otp_sel_pkg::CMD_POF, 1'b0);
        cmd(otp_sel_pkg::CMD_REV, 1'b1);
        chk(busy_n_ff, 1'b0);
        wait_out(1'b0, 2000);
        // float shows one cycle after the first stage is entered
        @(posedge sys_clk);
        #1 chk(vcom_float, 1'b1);
        wait_idle(8000);
        // blank boundaries read -1, so temperature 0 passes all of them
        rd(otp_sel_pkg::RA_STATUS, 16'h1f06, 16'h1002);
        wr(otp_sel_pkg::RA_LUT_IDX, 16'h0100);
        rd(otp_sel_pkg::RA_LUT_DATA, 16'h00ff, 16'h003c);
        wr(otp_sel_pkg::RA_LUT_IDX, 16'h0000);
        rd(otp_sel_pkg::RA_LUT_DATA, 16'h00ff, 16'h005a);
        // bank zero now valid and wins; register tables, two-colour
        wr(otp_sel_pkg::RA_OTP_ADDR, 16'h0000);
        wr(otp_sel_pkg::RA_OTP_DATA, 16'h00a5);
        wr(otp_sel_pkg::RA_OTP_ADDR, 16'h001d);
        wr(otp_sel_pkg::RA_OTP_DATA, 16'h0005);
        wr(otp_sel_pkg::RA_OTP_DATA, 16'h007f);
        wr(otp_sel_pkg::RA_TEMP, 16'h0005);
        wr(otp_sel_pkg::RA_CTRL, 16'h0003);
        cmd(otp_sel_pkg::CMD_DRF, 1'b1);
        wait_out(1'b0, 2000);
        wait_out(1'b1, 4000);
        chk(16'((cnt - 1) / otp_sel_pkg::FRAME_CYC), 16'h0006);
        chk({wave_active, zero_frames}, 2'b01);
        wait_idle(2000);
        chk(16'((cnt - 1) / otp_sel_pkg::FRAME_CYC), 16'h0002);
        rd(otp_sel_pkg::RA_STATUS, 16'h1f06, 16'h0300);
        rd(otp_sel_pkg::RA_LUT_DATA, 16'h00ff, 16'h005a);
        $display("refresh done");
    endtask
    task automatic report_and_stop;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        failures = 0;
        n_tests = 0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1 chk(busy_n_ff, 1'b1);
        t_flags();
        t_otp();
        t_refresh();
        report_and_stop();
    end
endmodule
`default_nettype wire
